// [rtl/spl_pkg.sv]
// Package for the split-port stuck-link supervisor: register map, timing, types
package spl_pkg;

  // Register bus widths and offsets
  localparam int unsigned ADDR_W          = 16;
  localparam logic [15:0] OFF_SPLIT_EN    = 16'h3c48;
  localparam logic [15:0] OFF_LINK_TMO    = 16'h4171;
  localparam logic [15:0] OFF_PULSE_LEN   = 16'h4176;

  // Reset values and field layout
  localparam logic [7:0]  RST_SPLIT_EN    = 8'h00;
  localparam logic [7:0]  RST_LINK_TMO    = 8'h05;
  localparam logic [7:0]  RST_PULSE_LEN   = 8'h05;
  localparam int unsigned TMO_SEL_W       = 3;
  localparam int unsigned FIRST_PORT      = 5;

  // Link state codes that count as not operational
  localparam logic [3:0]  LINK_BAD_LO     = 4'h4;
  localparam logic [3:0]  LINK_BAD_HI     = 4'h9;

  // Timing in the block's units
  localparam int unsigned CLK_MHZ         = 50;
  localparam int unsigned TICK_US         = 1000;
  localparam int unsigned TICK_CYC_DFLT   = TICK_US * CLK_MHZ;
  localparam int unsigned PULSE_BASE_MS   = 350;
  localparam int unsigned PULSE_STEP_MS   = 10;
  localparam logic [11:0] TMO_100_MS      = 12'd100;
  localparam logic [11:0] TMO_250_MS      = 12'd250;
  localparam logic [11:0] TMO_500_MS      = 12'd500;
  localparam logic [11:0] TMO_750_MS      = 12'd750;
  localparam logic [11:0] TMO_1000_MS     = 12'd1000;
  localparam logic [11:0] TMO_2000_MS     = 12'd2000;

  // Per-port supervisor states
  typedef enum logic [1:0] {
    SPL_WATCH = 2'b00,
    SPL_PULSE = 2'b01
  } spl_state_t;

  // Register bus request bundle
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } spl_req_t;

endpackage

// [rtl/spl_port_mon.sv]
// One port's stuck-link watchdog and power pulse generator
`timescale 1ns/1ns
module spl_port_mon
  import spl_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  // Controls
  input  wire logic        tick_in,
  input  wire logic        enable_in,
  input  wire logic [11:0] timeout_ms_in,
  input  wire logic [11:0] pulse_ms_in,
  input  wire logic [3:0]  link_state_in,
  // Power pin, high keeps the embedded device powered
  output logic             power_on_out
);

  spl_state_t  state_q;
  spl_state_t  state_d;
  logic [11:0] ms_q;
  logic [11:0] ms_d;
  logic [3:0]  last_q;
  logic        power_q;

  // Link is bad when in codes 0x4..0x9; a change of code proves activity
  wire link_bad  = (link_state_in >= LINK_BAD_LO) && (link_state_in <= LINK_BAD_HI);
  wire link_move = (link_state_in != last_q);
  wire armed     = enable_in && (timeout_ms_in != 12'h000);
  wire tmo_hit   = tick_in && (ms_q + 12'h001 >= timeout_ms_in);
  wire pulse_end = tick_in && (ms_q + 12'h001 >= pulse_ms_in);

  // Next state: watch, then pulse low, then restore power
  always_comb
  begin
    state_d = state_q;
    ms_d    = ms_q;
    case (state_q)
      SPL_WATCH:
      begin
        if (!armed || !link_bad || link_move)
          ms_d = 12'h000;
        else if (tmo_hit)
        begin
          state_d = SPL_PULSE;
          ms_d    = 12'h000;
        end
        else if (tick_in)
          ms_d = ms_q + 12'h001;
      end
      SPL_PULSE:
      begin
        if (pulse_end)
        begin
          state_d = SPL_WATCH;
          ms_d    = 12'h000;
        end
        else if (tick_in)
          ms_d = ms_q + 12'h001;
      end
      default:
      begin
        state_d = SPL_WATCH;
        ms_d    = 12'h000;
      end
    endcase
  end

  // State, timer and pin registers
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state_q <= SPL_WATCH;
      ms_q    <= 12'h000;
      last_q  <= 4'h0;
      power_q <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      ms_q    <= ms_d;
      last_q  <= link_state_in;
      power_q <= (state_d != SPL_PULSE);
    end
  end

  assign power_on_out = power_q;

  // Pin only drops after a full bad stretch with the port enabled
  a_pin_drop_cause: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $fell(power_q) |-> $past(enable_in) && $past(link_bad))
    else $error("power pin dropped without an enabled stuck link");

  // Disabled timeout never pulses
  a_no_pulse_off: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (timeout_ms_in == 12'h000) && power_q |=> power_q)
    else $error("power pin pulsed while timeout disabled");

  // Timer restarts at zero when the pin is restored
  a_timer_clear: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $rose(power_q) |-> ms_q == 12'h000)
    else $error("timer not cleared after pulse");

endmodule

// [rtl/spl_link_watchdog.sv]
// Top of the split-port stuck-link supervisor with its register file
`timescale 1ns/1ns
module spl_link_watchdog
  import spl_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYC_DFLT
)
(
  // Clock and reset
  input  wire logic        CLK_IN,
  input  wire logic        RESETN_IN,
  // Register bus
  input  wire logic [15:0] ADDR_IN,
  input  wire logic [7:0]  WDATA_IN,
  input  wire logic        WR_IN,
  input  wire logic        RD_IN,
  output logic      [7:0]  RDATA_OUT,
  // Configuration load path
  input  wire logic        CFG_LOAD_IN,
  input  wire logic [2:0]  CFG_TMO_IN,
  // Link state of ports 5 and 6
  input  wire logic [3:0]  LINK_STATE5_IN,
  input  wire logic [3:0]  LINK_STATE6_IN,
  // Embedded SuperSpeed power pins, low while resetting the device
  output logic      [1:0]  EMB_SS_POWER_OUT
);

  localparam int unsigned NPORT = 2;

  // Elaboration check: the divider cannot make a one-cycle-wide tick below two cycles
  if (TICK_CYC < 2)
  begin : g_bad_tick
    $error("TICK_CYC must be at least 2");
  end

  spl_req_t    req;
  logic [7:0]  split_en_q;
  logic [2:0]  tmo_sel_q;
  logic [7:0]  pulse_len_q;
  logic [7:0]  rdata_q;
  logic [31:0] tick_cnt_q;
  logic        tick_q;
  logic [11:0] timeout_ms;
  logic [11:0] pulse_ms;
  logic [3:0]  link_state [NPORT];
  logic [1:0]  power_on;

  assign req = '{addr: ADDR_IN, wdata: WDATA_IN, wr: WR_IN, rd: RD_IN};

  // Address decode
  wire hit_en  = (req.addr == OFF_SPLIT_EN);
  wire hit_tmo = (req.addr == OFF_LINK_TMO);
  wire hit_len = (req.addr == OFF_PULSE_LEN);

  // Read mux; reserved bits and unmapped addresses read zero
  wire [7:0] rd_mux = hit_en  ? {split_en_q[7:1], 1'b0} :
                      hit_tmo ? {5'h00, tmo_sel_q} :
                      hit_len ? pulse_len_q : 8'h00;

  // Register file writes; a configuration load wins over a bus write
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      split_en_q  <= RST_SPLIT_EN;
      tmo_sel_q   <= RST_LINK_TMO[2:0];
      pulse_len_q <= RST_PULSE_LEN;
      rdata_q     <= 8'h00;
    end
    else
    begin
      if (req.wr && hit_en)
        split_en_q <= {req.wdata[7:1], 1'b0};
      if (CFG_LOAD_IN)
        tmo_sel_q <= CFG_TMO_IN;
      else if (req.wr && hit_tmo)
        tmo_sel_q <= req.wdata[2:0];
      if (req.wr && hit_len)
        pulse_len_q <= req.wdata;
      rdata_q <= req.rd ? rd_mux : 8'h00;
    end
  end

  assign RDATA_OUT = rdata_q;

  // Timeout decode; the reserved code behaves as disabled
  always_comb
  begin
    case (tmo_sel_q)
      3'h1:    timeout_ms = TMO_100_MS;
      3'h2:    timeout_ms = TMO_250_MS;
      3'h3:    timeout_ms = TMO_500_MS;
      3'h4:    timeout_ms = TMO_750_MS;
      3'h5:    timeout_ms = TMO_1000_MS;
      3'h6:    timeout_ms = TMO_2000_MS;
      default: timeout_ms = 12'h000;
    endcase
  end

  // Pulse length in ms: base plus step per count
  assign pulse_ms = 12'(PULSE_BASE_MS) + 12'(PULSE_STEP_MS) * {4'h0, pulse_len_q};

  // Millisecond tick shared by both ports; keeps per-port timers narrow
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      tick_cnt_q <= 32'h0;
      tick_q     <= 1'b0;
    end
    else
    begin
      tick_q     <= (tick_cnt_q == 32'(TICK_CYC - 1));
      tick_cnt_q <= (tick_cnt_q == 32'(TICK_CYC - 1)) ? 32'h0 : tick_cnt_q + 32'h1;
    end
  end

  assign link_state[0] = LINK_STATE5_IN;
  assign link_state[1] = LINK_STATE6_IN;

  // One supervisor per split-capable port
  genvar p;
  generate
    for (p = 0; p < NPORT; p++)
    begin : g_port
      // Ticks seen while this pin is low, kept only for the checks below
      logic [11:0] low_ticks_q;

      spl_port_mon u_mon (
        .clk_in        (CLK_IN),
        .resetn_in     (RESETN_IN),
        .tick_in       (tick_q),
        .enable_in     (split_en_q[FIRST_PORT + p]),
        .timeout_ms_in (timeout_ms),
        .pulse_ms_in   (pulse_ms),
        .link_state_in (link_state[p]),
        .power_on_out  (power_on[p])
      );

      // Count pulse ticks; cleared whenever power is on
      always_ff @(posedge CLK_IN or negedge RESETN_IN)
      begin
        if (!RESETN_IN)
          low_ticks_q <= 12'h000;
        else if (power_on[p])
          low_ticks_q <= 12'h000;
        else
          low_ticks_q <= low_ticks_q + {11'h000, tick_q};
      end

      // A finished pulse covered at least the programmed length
      a_pulse_full_len: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        $rose(power_on[p]) |-> low_ticks_q >= $past(pulse_ms))
        else $error("power pulse ended early");

      // No pulse outlasts the longest programmable length
      a_pulse_max_len: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        !power_on[p] |-> low_ticks_q <= 12'(PULSE_BASE_MS + PULSE_STEP_MS * 255))
        else $error("power pulse longer than maximum");
    end
  endgenerate

  assign EMB_SS_POWER_OUT = power_on;

  // Reserved timeout bits always read zero
  a_tmo_rsvd_zero: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    req.rd && hit_tmo |=> RDATA_OUT[7:3] == 5'h00)
    else $error("reserved timeout bits read nonzero");

  // Read data only in the cycle after a read strobe
  a_rdata_idle: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    !req.rd |=> RDATA_OUT == 8'h00)
    else $error("read data outside read answer");

  // Reset pulse setting yields 400ms
  a_pulse_reset: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    pulse_len_q == RST_PULSE_LEN |-> pulse_ms == 12'd400)
    else $error("default pulse length not 400ms");

  // Configuration load takes effect next cycle
  a_cfg_override: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    CFG_LOAD_IN |=> tmo_sel_q == $past(CFG_TMO_IN))
    else $error("configuration load ignored");

  // Disabled port keeps its pin high
  a_port_off_high: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    !split_en_q[5] && EMB_SS_POWER_OUT[0] |=> EMB_SS_POWER_OUT[0])
    else $error("disabled port pin toggled");

  // Port 6 is guarded the same way as port 5
  a_port6_off_high: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    !split_en_q[6] && EMB_SS_POWER_OUT[1] |=> EMB_SS_POWER_OUT[1])
    else $error("disabled port 6 pin toggled");

  // Register bus steps; a load from configuration outranks a bus write
  sequence s_wr_en;
    req.wr && hit_en;
  endsequence

  sequence s_wr_tmo;
    req.wr && hit_tmo && !CFG_LOAD_IN;
  endsequence

  sequence s_cfg_over_wr;
    CFG_LOAD_IN && req.wr && hit_tmo;
  endsequence

  sequence s_wr_len;
    req.wr && hit_len;
  endsequence

  sequence s_rd_en;
    req.rd && hit_en;
  endsequence

  sequence s_rd_len;
    req.rd && hit_len;
  endsequence

  sequence s_rd_unmapped;
    req.rd && !hit_en && !hit_tmo && !hit_len;
  endsequence

  // Split enable write keeps bits 7:1 and forces the reserved bit low
  a_en_write: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    s_wr_en |=> split_en_q == {$past(WDATA_IN[7:1]), 1'b0})
    else $error("split enable write not stored");

  // Reserved enable bit reads zero whatever was written
  a_en_bit0_zero: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    s_rd_en |=> RDATA_OUT[0] == 1'b0)
    else $error("reserved split enable bit read nonzero");

  // Port enable bits read back as stored
  a_en_readback: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    s_rd_en |=> RDATA_OUT[6:5] == $past(split_en_q[6:5]))
    else $error("port enable bits read back wrong");

  // Timeout select write keeps only bits 2:0
  a_tmo_write: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    s_wr_tmo |=> tmo_sel_q == $past(WDATA_IN[2:0]))
    else $error("timeout select write not stored");

  // Configuration load wins over a bus write in the same cycle
  a_cfg_wins: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    s_cfg_over_wr |=> tmo_sel_q == $past(CFG_TMO_IN))
    else $error("bus write beat configuration load");

  // Pulse length register takes all eight bits
  a_len_write: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    s_wr_len |=> pulse_len_q == $past(WDATA_IN))
    else $error("pulse length write not stored");

  // Pulse length reads back whole
  a_len_readback: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    s_rd_len |=> RDATA_OUT == $past(pulse_len_q))
    else $error("pulse length read back wrong");

  // Unmapped addresses answer zero
  a_unmapped_zero: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    s_rd_unmapped |=> RDATA_OUT == 8'h00)
    else $error("unmapped read returned data");

  // Disabled and reserved selects give no timeout at all
  a_tmo_off_codes: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    (tmo_sel_q == 3'h0) || (tmo_sel_q == 3'h7) |-> timeout_ms == 12'h000)
    else $error("disabled select gave a timeout");

  // Shortest timeout code
  a_tmo_short: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    tmo_sel_q == 3'h1 |-> timeout_ms == TMO_100_MS)
    else $error("shortest timeout decoded wrong");

  // Reset select means one second
  a_tmo_reset_1s: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    tmo_sel_q == RST_LINK_TMO[2:0] |-> timeout_ms == TMO_1000_MS)
    else $error("reset timeout select not one second");

  // Longest timeout code
  a_tmo_long: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    tmo_sel_q == 3'h6 |-> timeout_ms == TMO_2000_MS)
    else $error("longest timeout decoded wrong");

  // Zero setting gives the base pulse length
  a_pulse_base: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    pulse_len_q == 8'h00 |-> pulse_ms == 12'(PULSE_BASE_MS))
    else $error("zero pulse setting not base length");

  // Full-scale setting gives the longest pulse; must still fit 12 bits
  a_pulse_top: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    pulse_len_q == 8'hff |-> pulse_ms == 12'(PULSE_BASE_MS + PULSE_STEP_MS * 255))
    else $error("full pulse setting wrong length");

  // Tick is launched as the divider wraps
  a_tick_wrap: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    tick_q |-> tick_cnt_q == 32'h0)
    else $error("tick out of step with divider");

  // Tick is one cycle wide so timers never count twice
  a_tick_single: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    tick_q |=> !tick_q)
    else $error("tick wider than one cycle");

endmodule

// [verification/spl_emb_dev.sv]
// Model of the embedded SuperSpeed device as its link state appears to the hub
`timescale 1ns/1ns
module spl_emb_dev
(
  // Clock
  input  wire logic       clk_in,
  // Power pin from the hub and scenario controls
  input  wire logic       power_on_in,
  input  wire logic       stuck_in,
  input  wire logic [3:0] stuck_code_in,
  // Link state reported to the hub
  output logic      [3:0] link_state_out
);
  logic [3:0] walk_q = 4'h0;

  // A healthy link changes state every cycle; a stuck or unpowered one holds one code
  always @(posedge clk_in)
  begin
    walk_q         <= walk_q + 4'h1;
    link_state_out <= (stuck_in || !power_on_in) ? stuck_code_in : walk_q;
  end
endmodule

// [verification/split_port_link_stuck_reset_test.sv]
// Self-checking bench for the split-port stuck-link supervisor
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin num_errors++; \
  $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module split_port_link_stuck_reset_test;
  import spl_pkg::*;
  // Short tick keeps millisecond counts affordable in simulation
  localparam int unsigned TK = 4;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  rdata;
  logic        cfg_ld = 1'b0;
  logic [2:0]  cfg_tmo = 3'h0;
  logic [3:0]  ls5;
  logic [3:0]  ls6;
  logic [1:0]  pwr;
  logic        stuck = 1'b0;
  logic [3:0]  code = 4'h5;
  logic        other_bad;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          tmo_ms [7] = '{0, 100, 250, 500, 750, 1000, 2000};

  always #10 clk = ~clk;

  spl_link_watchdog #(.TICK_CYC(TK)) i_dut (.CLK_IN(clk), .RESETN_IN(resetn), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .CFG_LOAD_IN(cfg_ld),
    .CFG_TMO_IN(cfg_tmo), .LINK_STATE5_IN(ls5), .LINK_STATE6_IN(ls6), .EMB_SS_POWER_OUT(pwr));
  spl_emb_dev i_dev5 (.clk_in(clk), .power_on_in(pwr[0]), .stuck_in(stuck),
    .stuck_code_in(code), .link_state_out(ls5));
  spl_emb_dev i_dev6 (.clk_in(clk), .power_on_in(pwr[1]), .stuck_in(stuck),
    .stuck_code_in(code), .link_state_out(ls6));

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] ex);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    `CHK("rdata", ex, rdata)
  endtask

  // Count cycles until pin p reaches lvl, watching that the other pin stays high
  task automatic wait_pin(input int p, input logic lvl, input int lim, output int n);
    n = 0;
    while (pwr[p] !== lvl && n < lim)
    begin
      @(posedge clk);
      #1;
      if (pwr[1 - p] !== 1'b1)
        other_bad = 1'b1;
      n++;
    end
  endtask

  function automatic logic near(input int a, input int b);
    return (a >= b - 3 * TK) && (a <= b + 3 * TK);
  endfunction

  // Stuck link on one enabled port: timeout, pulse length, restart
  task automatic run(input int p, input int sel, input logic [7:0] len, input logic [3:0] c);
    int n;
    wr_reg(OFF_SPLIT_EN, 8'(8'h20 << p));
    wr_reg(OFF_LINK_TMO, 8'(sel));
    wr_reg(OFF_PULSE_LEN, len);
    other_bad = 1'b0;
    @(posedge clk);
    code  <= c;
    stuck <= 1'b1;
    wait_pin(p, 1'b0, 3000 * TK, n);
    `CHK("timeout", 1'b1, near(n, tmo_ms[sel] * TK))
    wait_pin(p, 1'b1, 3000 * TK, n);
    `CHK("pulse", 1'b1, near(n, (350 + 10 * int'(len)) * TK))
    wait_pin(p, 1'b0, 3000 * TK, n);
    `CHK("restart", 1'b1, near(n, tmo_ms[sel] * TK))
    stuck <= 1'b0;
    wait_pin(p, 1'b1, 3000 * TK, n);
    `CHK("other pin", 1'b0, other_bad)
  endtask

  // Link held in one code while supervision must stay quiet
  task automatic quiet(input logic [2:0] sel, input logic [3:0] c);
    int n;
    wr_reg(OFF_SPLIT_EN, 8'h60);
    wr_reg(OFF_LINK_TMO, {5'h00, sel});
    other_bad = 1'b0;
    @(posedge clk);
    code  <= c;
    stuck <= 1'b1;
    wait_pin(0, 1'b0, 300 * TK, n);
    `CHK("no pulse", 2'b01, {other_bad, pwr[0]})
    stuck <= 1'b0;
  endtask

  task automatic results();
    if (num_errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Cut a hang short well beyond the expected run length
  initial
  begin
    #1800000;
    num_errors++;
    results();
  end

  initial
  begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    rd_chk(OFF_SPLIT_EN, 8'h00);
    rd_chk(OFF_LINK_TMO, 8'h05);
    rd_chk(OFF_PULSE_LEN, 8'h05);
    rd_chk(16'h4172, 8'h00);
    wr_reg(OFF_LINK_TMO, 8'hff);
    rd_chk(OFF_LINK_TMO, 8'h07);
    wr_reg(OFF_SPLIT_EN, 8'hff);
    rd_chk(OFF_SPLIT_EN, 8'hfe);
    @(posedge clk);
    cfg_ld  <= 1'b1;
    cfg_tmo <= 3'h2;
    @(posedge clk);
    cfg_ld  <= 1'b0;
    rd_chk(OFF_LINK_TMO, 8'h02);
    for (int i = 1; i <= 6; i++)
      run(i % 2, i, 8'((i - 1) * 5), 4'(i + 3));
    quiet(3'h0, 4'h5);
    quiet(3'h7, 4'h9);
    quiet(3'h1, 4'h3);
    quiet(3'h1, 4'ha);
    results();
  end
endmodule
